// >>> pcb_pkg.sv
// Shared constants for the parallel processor bus port.
package pcb_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  // Internal clock period in ns; the documented cycle figures are in these units.
  localparam int unsigned INTERNAL_CLOCK_PERIOD_NS = 100;
  // RAM-backed read takes five internal clock periods.
  localparam int unsigned RAM_READ_PERIODS = 5;
  localparam int unsigned RAM_READ_CYCLES =
    (RAM_READ_PERIODS * INTERNAL_CLOCK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // FIFO access busy time after a byte and after a word, in internal clock periods.
  localparam int unsigned FIFO_BYTE_PERIODS = 3;
  localparam int unsigned FIFO_WORD_PERIODS = 4;
  localparam logic [3:0] FIFO_BYTE_CYCLES = 4'(FIFO_BYTE_PERIODS * INTERNAL_CLOCK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [3:0] FIFO_WORD_CYCLES = 4'(FIFO_WORD_PERIODS * INTERNAL_CLOCK_PERIOD_NS / CLK_PERIOD_NS);
  localparam logic [3:0] RAM_CYCLES = 4'(RAM_READ_CYCLES);
  // Address class codes from the two top address bits.
  localparam logic [1:0] CLASS_FIFO = 2'h2;
  localparam logic [1:0] CLASS_RAM = 2'h3;
  localparam logic [7:0] RESET_ADDR = 8'h00;
  localparam logic [7:0] RESET_HOLD = 8'h00;
  typedef enum logic [1:0] {
    PCB_MODE_STROBE_DIR = 2'b00,
    PCB_MODE_SEPARATE = 2'b01,
    PCB_MODE_MUX = 2'b10
  } pcb_mode_t;
  typedef enum logic [1:0] {
    PCB_IDLE = 2'b00,
    PCB_FETCH = 2'b01,
    PCB_FIFO_BUSY = 2'b10
  } pcb_state_t;
endpackage

// >>> pcb_sync.sv
`timescale 1ns/10ps
// Two flip-flop synchroniser for a group of asynchronous pins.
module pcb_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// >>> pcb_host_port.sv
`timescale 1ns/10ps
// Slave side of the parallel processor bus in the three supported strobe modes.
// Behaviour
// - Reading top address quarter starts a RAM fetch; short-strobe data is stale.
// - After the fetch, the byte is held in the interrupt-data holding register.
// - Top address bits classify: normal (bit 7 low), FIFO data and RAM.
// - Direction mode drives data with lanes enabled, strobe and select low, direction high.
// - Separate-strobe mode drives data with lanes enabled, read low, write strobe high.
// - Write data captured at the rising edge of the combined write strobe.
// - Lane enables with address bit0 choose low byte, high byte or word.
// - Reads of any class may be words; RAM-class reads return one byte.
// - Only FIFO data writes may be words; others are bytes.
// - Multiplexed mode drives the low byte with lane zero enabled and read active.
// - Multiplexed mode keeps the latched address for later accesses.
// - Multiplexed mode writes low lanes at the rising combined write strobe edge.
// - Multiplexed mode latches the address from low lines at latch strobe fall.
// - First latch strobe rise after reset enters multiplexed mode for good.
module pcb_host_port (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic strobe_n,
  input wire logic rw_write_n,
  input wire logic addr_latch,
  input wire logic [7:0] addr,
  input wire logic lane0_enable_n,
  input wire logic lane1_enable_n,
  input wire logic lane2_enable_n,
  input wire logic lane3_enable_n,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [1:0] data_oe,
  output logic [1:0] mode,
  output logic reg_wr,
  output logic [7:0] reg_wr_addr,
  output logic [15:0] reg_wr_data,
  output logic [1:0] reg_wr_lanes,
  output logic reg_wr_error,
  output logic reg_rd,
  output logic [7:0] reg_rd_addr,
  output logic ram_req,
  output logic [7:0] ram_addr,
  input wire logic ram_ack,
  input wire logic [7:0] ram_data,
  input wire logic [15:0] reg_rd_data,
  output logic [7:0] int_data_hold,
  output logic busy
);
  logic [2:0] ctl_sync;
  logic cs_s;
  logic strobe_s;
  logic rw_s;
  logic ale_s;
  logic [7:0] addr_s;
  logic [1:0] lanes_s;
  logic [15:0] data_s;
  logic strobe_d;
  logic ale_d;
  logic active_d;
  logic mode_taken;
  logic [7:0] mux_addr;
  logic [7:0] cur_addr;
  logic read_active;
  logic write_active;
  logic active;
  logic active_rise;
  logic active_fall;
  logic [1:0] lanes_ok;
  logic lane_valid;
  logic is_word;
  pcb_pkg::pcb_state_t state;
  logic [3:0] count;
  logic [7:0] fetch_addr;
  logic [7:0] ram_shadow;

  // Each control pin gets its own synchroniser; gating raw pins first could pass a glitch inward.
  pcb_sync #(.WIDTH(3), .INIT(3'h7)) u_sync_ctl (
    .clk(clk),
    .reset(reset),
    .async_in({chip_select_n, strobe_n, rw_write_n}),
    .sync_out(ctl_sync)
  );
  // The latch pin synchroniser runs through reset so the strap level is settled at the first edge after it.
  pcb_sync #(.WIDTH(1), .INIT(1'b0)) u_sync_ale (
    .clk(clk),
    .reset(1'b0),
    .async_in(addr_latch),
    .sync_out(ale_s)
  );
  pcb_sync #(.WIDTH(26), .INIT(26'h0)) u_sync_bus (
    .clk(clk),
    .reset(reset),
    .async_in({addr, lane1_enable_n, lane0_enable_n, data_in}),
    .sync_out({addr_s, lanes_s, data_s})
  );
  assign cs_s = ctl_sync[2];
  assign strobe_s = ctl_sync[1] | cs_s;
  assign rw_s = ctl_sync[0];

  // Byte-lane decode for a 16-bit host; the upper two enables are not decoded.
  function automatic logic [1:0] lane_decode(input logic [1:0] en_n, input logic a0);
    case ({en_n, a0})
      3'b100: lane_decode = 2'b01;
      3'b011: lane_decode = 2'b10;
      3'b000: lane_decode = 2'b11;
      default: lane_decode = 2'b00;
    endcase
  endfunction

  function automatic logic [1:0] addr_class(input logic [7:0] a);
    addr_class = a[7] ? a[7:6] : 2'b00;
  endfunction

  // Mode: strap level picks the non-multiplexed flavour until the first latch rise.
  always_ff @(posedge clk) begin
    if (reset) begin
      mode_taken <= 1'b0;
      mode <= pcb_pkg::PCB_MODE_STROBE_DIR;
      ale_d <= 1'b0;
    end else begin
      ale_d <= ale_s;
      if (!mode_taken) begin
        mode_taken <= 1'b1;
        mode <= ale_s ? pcb_pkg::PCB_MODE_STROBE_DIR : pcb_pkg::PCB_MODE_SEPARATE;
      end else if (mode != pcb_pkg::PCB_MODE_MUX && ale_s && !ale_d) begin
        mode <= pcb_pkg::PCB_MODE_MUX;
      end
    end
  end

  // Address latched at the falling latch edge and kept for repeated accesses.
  always_ff @(posedge clk) begin
    if (reset) begin
      mux_addr <= pcb_pkg::RESET_ADDR;
    end else if (mode == pcb_pkg::PCB_MODE_MUX && !ale_s && ale_d) begin
      mux_addr <= data_s[7:0];
    end
  end

  assign cur_addr = (mode == pcb_pkg::PCB_MODE_MUX) ? mux_addr : addr_s;
  assign active = !strobe_s;
  // In direction mode the second pin is the direction; otherwise it is the write strobe.
  assign read_active = active && rw_s;
  // The write strobe counts only together with the chip select, as the read strobe does.
  always_comb begin
    if (mode == pcb_pkg::PCB_MODE_STROBE_DIR) begin
      write_active = active && !rw_s;
    end else begin
      write_active = !(rw_s | cs_s);
    end
  end
  assign lanes_ok = lane_decode(lanes_s, cur_addr[0]);
  assign lane_valid = lanes_ok != 2'b00;
  assign is_word = lanes_ok == 2'b11;

  always_ff @(posedge clk) begin
    if (reset) begin
      strobe_d <= 1'b0;
      active_d <= 1'b0;
    end else begin
      strobe_d <= read_active;
      active_d <= write_active;
    end
  end
  assign active_rise = read_active && !strobe_d;
  assign active_fall = !write_active && active_d;

  // Output enables follow the pins directly so the bus turns on and off without delay.
  // Lanes two and three are never driven, so their enables are not decoded.
  always_comb begin
    data_oe = 2'b00;
    case (mode)
      pcb_pkg::PCB_MODE_STROBE_DIR: begin
        if (!(strobe_n | chip_select_n) && rw_write_n) begin
          data_oe = {!lane1_enable_n, !lane0_enable_n};
        end
      end
      pcb_pkg::PCB_MODE_SEPARATE: begin
        if (!(strobe_n | chip_select_n) && rw_write_n) begin
          data_oe = {!lane1_enable_n, !lane0_enable_n};
        end
      end
      pcb_pkg::PCB_MODE_MUX: begin
        if (!(strobe_n | chip_select_n) && rw_write_n) begin
          data_oe = {1'b0, !lane0_enable_n};
        end
      end
      default: data_oe = 2'b00;
    endcase
  end

  // Read data: RAM-backed registers return the shadow, which is stale until the fetch ends.
  always_ff @(posedge clk) begin
    if (reset) begin
      data_out <= 16'h0000;
    end else if (read_active) begin
      if (addr_class(cur_addr) == pcb_pkg::CLASS_RAM) begin
        data_out <= {8'h00, ram_shadow};
      // A high-byte read moves the register's byte onto the upper lane.
      end else if (cur_addr[0] && lanes_ok == 2'b10) begin
        data_out <= {reg_rd_data[7:0], 8'h00};
      end else begin
        data_out <= reg_rd_data;
      end
    end
  end

  // Register write strobe at the rising edge of the combined write strobe.
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_wr <= 1'b0;
      reg_wr_addr <= pcb_pkg::RESET_ADDR;
      reg_wr_data <= 16'h0000;
      reg_wr_lanes <= 2'b00;
      reg_wr_error <= 1'b0;
    end else begin
      reg_wr <= 1'b0;
      reg_wr_error <= 1'b0;
      if (active_fall && lane_valid) begin
        reg_wr_addr <= cur_addr;
        reg_wr_lanes <= (mode == pcb_pkg::PCB_MODE_MUX) ? 2'b01 : lanes_ok;
        reg_wr_data <= data_s;
        // A refused word write still leaves its address and data captured for inspection.
        if (is_word && addr_class(cur_addr) != pcb_pkg::CLASS_FIFO) begin
          reg_wr_error <= 1'b1;
        end else begin
          reg_wr <= 1'b1;
        end
      end
    end
  end

  // Read request and RAM fetch sequencing.
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= pcb_pkg::PCB_IDLE;
      count <= 4'h0;
      reg_rd <= 1'b0;
      reg_rd_addr <= pcb_pkg::RESET_ADDR;
      ram_req <= 1'b0;
      fetch_addr <= pcb_pkg::RESET_ADDR;
    end else begin
      reg_rd <= 1'b0;
      case (state)
        pcb_pkg::PCB_IDLE: begin
          if (active_rise && lane_valid) begin
            reg_rd_addr <= cur_addr;
            reg_rd <= 1'b1;
            if (addr_class(cur_addr) == pcb_pkg::CLASS_RAM) begin
              ram_req <= 1'b1;
              fetch_addr <= cur_addr;
              count <= pcb_pkg::RAM_CYCLES;
              state <= pcb_pkg::PCB_FETCH;
            end else if (addr_class(cur_addr) == pcb_pkg::CLASS_FIFO) begin
              count <= is_word ? pcb_pkg::FIFO_WORD_CYCLES : pcb_pkg::FIFO_BYTE_CYCLES;
              state <= pcb_pkg::PCB_FIFO_BUSY;
            end
          end else if (active_fall && lane_valid && addr_class(cur_addr) == pcb_pkg::CLASS_FIFO) begin
            count <= is_word ? pcb_pkg::FIFO_WORD_CYCLES : pcb_pkg::FIFO_BYTE_CYCLES;
            state <= pcb_pkg::PCB_FIFO_BUSY;
          end
        end
        pcb_pkg::PCB_FETCH: begin
          if (count != 4'h0) begin
            count <= count - 4'h1;
          end
          if (ram_ack) begin
            ram_req <= 1'b0;
            state <= pcb_pkg::PCB_IDLE;
          end
        end
        // Reads arriving in this time are not queued; the host's cycle time keeps them apart.
        pcb_pkg::PCB_FIFO_BUSY: begin
          if (count <= 4'h1) begin
            state <= pcb_pkg::PCB_IDLE;
          end
          count <= count - 4'h1;
        end
        default: state <= pcb_pkg::PCB_IDLE;
      endcase
    end
  end
  assign ram_addr = fetch_addr;
  assign busy = state != pcb_pkg::PCB_IDLE;

  // The fetched byte lands in the target shadow and in the holding register.
  always_ff @(posedge clk) begin
    if (reset) begin
      ram_shadow <= pcb_pkg::RESET_HOLD;
      int_data_hold <= pcb_pkg::RESET_HOLD;
    end else if (state == pcb_pkg::PCB_FETCH && ram_ack) begin
      ram_shadow <= ram_data;
      int_data_hold <= ram_data;
    end
  end
endmodule

// >>> pcb_host_port_chk.sv
`timescale 1ns/10ps
// Port checker for the parallel processor bus port.
module pcb_host_port_chk (
  input wire logic clk,
  input wire logic reset,
  input wire logic chip_select_n,
  input wire logic strobe_n,
  input wire logic rw_write_n,
  input wire logic lane0_enable_n,
  input wire logic lane1_enable_n,
  input wire logic [1:0] data_oe,
  input wire logic [1:0] mode,
  input wire logic reg_wr,
  input wire logic reg_wr_error,
  input wire logic [7:0] reg_wr_addr,
  input wire logic [1:0] reg_wr_lanes,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rd_addr,
  input wire logic ram_req,
  input wire logic ram_ack,
  input wire logic [7:0] ram_data,
  input wire logic [7:0] int_data_hold
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic rd_on;
  logic [1:0] oe_exp;
  assign rd_on = !(strobe_n | chip_select_n) & rw_write_n;
  assign oe_exp = {2{rd_on}} & ~{lane1_enable_n, lane0_enable_n};
  sequence s_top_rd;
    reg_rd ##0 reg_rd_addr[7:6] == pcb_pkg::CLASS_RAM;
  endsequence
  sequence s_fetch_end;
    ram_req ##0 ram_ack;
  endsequence
  AST_OE_DIR: assert property (mode == pcb_pkg::PCB_MODE_STROBE_DIR |-> data_oe == oe_exp)
    else $error("data enable wrong in direction mode");
  AST_OE_SEP: assert property (mode == pcb_pkg::PCB_MODE_SEPARATE |-> data_oe == oe_exp)
    else $error("data enable wrong in separate strobe mode");
  AST_OE_MUX: assert property (mode == pcb_pkg::PCB_MODE_MUX |-> data_oe == {1'b0, oe_exp[0]})
    else $error("data enable wrong in multiplexed mode");
  AST_MUX_STAYS: assert property (mode == pcb_pkg::PCB_MODE_MUX |=> mode == pcb_pkg::PCB_MODE_MUX)
    else $error("multiplexed mode left");
  AST_FETCH_START: assert property (s_top_rd |-> ##[0:1] ram_req)
    else $error("top quarter read did not fetch");
  AST_HOLD_BYTE: assert property (s_fetch_end |=> int_data_hold == $past(ram_data))
    else $error("fetched byte not held");
  AST_REQ_STANDS: assert property (ram_req && !ram_ack |=> ram_req)
    else $error("fetch request dropped early");
  AST_WR_WIDTH: assert property (reg_wr |-> reg_wr_lanes != 2'b11 || reg_wr_addr[7:6] == pcb_pkg::CLASS_FIFO)
    else $error("word write outside fifo range");
  AST_WR_EDGE: assert property (!(lane0_enable_n && lane1_enable_n) &&
    ((mode == pcb_pkg::PCB_MODE_STROBE_DIR && $rose(strobe_n | chip_select_n) && !rw_write_n) ||
    (mode != pcb_pkg::PCB_MODE_STROBE_DIR && $rose(rw_write_n | chip_select_n))) |-> ##[1:5] reg_wr || reg_wr_error)
    else $error("write strobe end not taken");
endmodule
bind pcb_host_port pcb_host_port_chk chk (
  .clk(clk),
  .reset(reset),
  .chip_select_n(chip_select_n),
  .strobe_n(strobe_n),
  .rw_write_n(rw_write_n),
  .lane0_enable_n(lane0_enable_n),
  .lane1_enable_n(lane1_enable_n),
  .data_oe(data_oe),
  .mode(mode),
  .reg_wr(reg_wr),
  .reg_wr_error(reg_wr_error),
  .reg_wr_addr(reg_wr_addr),
  .reg_wr_lanes(reg_wr_lanes),
  .reg_rd(reg_rd),
  .reg_rd_addr(reg_rd_addr),
  .ram_req(ram_req),
  .ram_ack(ram_ack),
  .ram_data(ram_data),
  .int_data_hold(int_data_hold)
);

// >>> pcb_host_model.sv
`timescale 1ns/10ps
// Host processor model driving the parallel bus pins.
module pcb_host_model (
  input wire logic clk,
  output logic chip_select_n = 1'b1,
  output logic strobe_n = 1'b1,
  output logic rw_write_n = 1'b1,
  output logic addr_latch = 1'b1,
  output logic [7:0] addr = 8'h00,
  output logic lane0_enable_n = 1'b1,
  output logic lane1_enable_n = 1'b1,
  output logic lane2_enable_n = 1'b1,
  output logic lane3_enable_n = 1'b1,
  output logic [15:0] data_in = 16'h0000,
  input wire logic [15:0] data_out
);
  task automatic acc(input int m, input bit wr, input bit latch, input logic [7:0] a, input logic [1:0] ln,
                     input logic [15:0] wd, input int hold, output logic [15:0] rd);
    if (latch) begin
      data_in[7:0] = a;
      addr_latch = 1'b1;
      repeat (2) @(negedge clk);
      addr_latch = 1'b0;
      @(negedge clk);
    end
    // Junk on the address pins in multiplexed mode, so only the latched address can serve.
    addr = (m == 2) ? ~a : a;
    {lane1_enable_n, lane0_enable_n} = ln;
    data_in = wr ? wd : ~data_in;
    rw_write_n = !wr;
    strobe_n = wr && m != 0;
    chip_select_n = 1'b0;
    repeat (hold) @(negedge clk);
    rd = data_out;
    chip_select_n = 1'b1;
    strobe_n = 1'b1;
    @(negedge clk);
    rw_write_n = 1'b1;
    {lane1_enable_n, lane0_enable_n} = 2'b11;
    data_in = ~data_in;
    // Seven cycles of rest cover the longest cycle and idle time of the normal and FIFO classes; a RAM fetch lasts until ram_ack.
    repeat (7) @(negedge clk);
  endtask
endmodule

// >>> parallel_cpu_bus_access_bench.sv
`timescale 1ns/10ps
// Self-checking bench for the parallel processor bus port.
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end
module parallel_cpu_bus_access_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ram_ack = 1'b0;
  logic [7:0] ram_data = 8'h00;
  logic [15:0] reg_rd_data = 16'h0000;
  logic chip_select_n, strobe_n, rw_write_n, addr_latch, lane0_enable_n, lane1_enable_n, lane2_enable_n;
  logic lane3_enable_n, reg_wr, reg_wr_error, reg_rd, ram_req, busy;
  logic [7:0] addr, reg_wr_addr, reg_rd_addr, ram_addr, int_data_hold, a, last_a, last_ram;
  logic [15:0] data_in, data_out, reg_wr_data, rd, wd, mask, exp_rd;
  logic [1:0] data_oe, mode, reg_wr_lanes, ln, em;
  int error_cnt = 0, n_compared = 0, n_wr = 0, n_err = 0, code, k;
  always #50 clk = ~clk;
  pcb_host_model host (
    .clk(clk),
    .chip_select_n(chip_select_n),
    .strobe_n(strobe_n),
    .rw_write_n(rw_write_n),
    .addr_latch(addr_latch),
    .addr(addr),
    .lane0_enable_n(lane0_enable_n),
    .lane1_enable_n(lane1_enable_n),
    .lane2_enable_n(lane2_enable_n),
    .lane3_enable_n(lane3_enable_n),
    .data_in(data_in),
    .data_out(data_out)
  );
  pcb_host_port dut (
    .clk(clk),
    .reset(reset),
    .chip_select_n(chip_select_n),
    .strobe_n(strobe_n),
    .rw_write_n(rw_write_n),
    .addr_latch(addr_latch),
    .addr(addr),
    .lane0_enable_n(lane0_enable_n),
    .lane1_enable_n(lane1_enable_n),
    .lane2_enable_n(lane2_enable_n),
    .lane3_enable_n(lane3_enable_n),
    .data_in(data_in),
    .data_out(data_out),
    .data_oe(data_oe),
    .mode(mode),
    .reg_wr(reg_wr),
    .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data),
    .reg_wr_lanes(reg_wr_lanes),
    .reg_wr_error(reg_wr_error),
    .reg_rd(reg_rd),
    .reg_rd_addr(reg_rd_addr),
    .ram_req(ram_req),
    .ram_addr(ram_addr),
    .ram_ack(ram_ack),
    .ram_data(ram_data),
    .reg_rd_data(reg_rd_data),
    .int_data_hold(int_data_hold),
    .busy(busy)
  );
  always @(posedge clk) begin
    if (reg_wr === 1'b1) n_wr++;
    if (reg_wr_error === 1'b1) n_err++;
    if (ram_req && ram_ack) last_ram = ram_data;
  end
  // The memory side stalls at random and shows fresh junk whenever it is not answering.
  always @(negedge clk) begin
    ram_ack <= ram_req && !ram_ack && $urandom_range(0, 1) == 1;
    ram_data <= 8'($urandom);
  end
  task complete_run;
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task do_reset(input logic ale);
    reset = 1'b1;
    repeat (6) @(negedge clk) host.addr_latch = ~host.addr_latch;
    // The strap must settle through both synchroniser stages before reset ends.
    host.addr_latch = ale;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  initial begin
    void'($urandom(18860));
    for (int m = 0; m < 3; m++) begin
      if (m < 2) do_reset(m == 0);
      em = (m == 0) ? pcb_pkg::PCB_MODE_STROBE_DIR : pcb_pkg::PCB_MODE_SEPARATE;
      `CHK("mode", em, mode)
      for (int i = 0; i < 24; i++) begin
        code = (m == 2) ? 0 : $urandom_range(0, 2);
        a = 8'($urandom);
        wd = 16'($urandom);
        reg_rd_data = 16'($urandom);
        if (a[7:6] == 2'b11) a[7] = 1'b0;
        if (code == 2) a[7:6] = pcb_pkg::CLASS_FIFO;
        a[0] = code == 1;
        if (m == 2 && i[0]) a = last_a;
        last_a = a;
        ln = (code == 0) ? 2'b10 : (code == 1) ? 2'b01 : 2'b00;
        mask = {{8{!ln[1]}}, {8{!ln[0]}}};
        host.acc(m, 1'b1, m == 2 && !i[0], a, ln, wd, 2, rd);
        `CHK("write address", a, reg_wr_addr)
        `CHK("write lanes", ~ln, reg_wr_lanes)
        `CHK("write data", wd & mask, reg_wr_data & mask)
        host.acc(m, 1'b0, 1'b0, a, ln, wd, 6, rd);
        `CHK("read address", a, reg_rd_addr)
        // A high-byte read returns the register's byte on the upper lane.
        exp_rd = (ln == 2'b01) ? {reg_rd_data[7:0], 8'h00} : (reg_rd_data & mask);
        `CHK("read data", exp_rd, rd & mask)
      end
      a = 8'hc0 | 8'(2 * $urandom_range(0, 31));
      host.acc(m, 1'b0, m == 2, a, 2'b10, wd, 1, rd);
      for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge clk);
      `CHK("fetch finished", 1'b0, busy)
      `CHK("fetch address", a, ram_addr)
      `CHK("held byte", last_ram, int_data_hold)
      if (k == 100) complete_run();
      if (m == 0) begin
        host.acc(0, 1'b1, 1'b0, 8'h10, 2'b00, wd, 2, rd);
        `CHK("word write refusals", 1, n_err)
      end
    end
    `CHK("mode", pcb_pkg::PCB_MODE_MUX, mode)
    `CHK("write count", 72, n_wr)
    complete_run();
  end
endmodule
